// ==== cpt_consts.svh ====
// Byte offsets, field positions and reset values of the timer control slice.
// Assumes inclusion by bare name from the design files and the bench; the package does not include it.
`ifndef CPT_CONSTS_SVH
`define CPT_CONSTS_SVH

// Register byte offsets on the 32-bit bus.
`define CPT_OFS_CTRL       8'h00
`define CPT_OFS_PRESC_LO   8'h04
`define CPT_OFS_PRESC_HI   8'h08
`define CPT_OFS_MAIN       8'h0C
`define CPT_OFS_PERIOD     8'h10
`define CPT_OFS_IRQ_STAT   8'h14
`define CPT_OFS_IRQ_CLR    8'h18
`define CPT_OFS_IRQ_EN     8'h1C

// Control word field positions.
`define CPT_BIT_FLAG       15
`define CPT_BIT_IRQ_EN     14
`define CPT_BIT_FREE       11
`define CPT_BIT_SOFT       10
`define CPT_BIT_RELOAD     5
`define CPT_BIT_HALT       4

// Interrupt status, clear and enable share one layout.
`define CPT_BIT_EV_ZERO    0

// Reset values.
`define CPT_RST_DIVIDE     16'h0000
`define CPT_RST_PRESC      16'h0000
`define CPT_RST_PERIOD     32'hFFFF_FFFF
`define CPT_RST_MAIN       32'hFFFF_FFFF

`endif

// ==== cpt_pkg.sv ====
// Types shared by the timer control slice.
// Assumes the constants header is compiled alongside.
`default_nettype none
package cpt_pkg;

    // Bus slave progress through a transfer.
    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b00,
        BUS_WRITE  = 2'b01,
        BUS_RDWAIT = 2'b10,
        BUS_RDOUT  = 2'b11
    } cpt_bus_state_type;

endpackage
`default_nettype wire

// ==== cpt_prescaler.sv ====
// Sixteen-bit prescale counter of the timer.
// Assumes run and reload are synchronous single-clock controls.
`timescale 1ns/100ps
`default_nettype none
`include "cpt_consts.svh"

module cpt_prescaler (
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Control.
    input  wire logic        run,
    input  wire logic        reload,
    input  wire logic [15:0] divide_down,
    // State.
    output logic      [15:0] count_q,
    output logic             tick
);

    // A tick is the cycle the count sits at zero while running.
    assign tick = run && (count_q == 16'h0000);

    // Count down, reload from the divide-down value at zero or on a strobe.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= `CPT_RST_PRESC;
        end else if (reload) begin
            count_q <= divide_down;
        end else if (run) begin
            if (count_q == 16'h0000) begin
                count_q <= divide_down;
            end else begin
                count_q <= count_q - 16'h0001;
            end
        end
    end

    // A running nonzero count falls by exactly one.
    property p_count_down;
        @(posedge hclk) disable iff (!hresetn)
        (run && !reload && count_q != 16'h0000) |=> (count_q == $past(count_q) - 16'h0001);
    endproperty
    a_count_down: assert property (p_count_down) else $error("prescale did not step down");

    // At zero the next count is the divide-down value.
    property p_reload_at_zero;
        @(posedge hclk) disable iff (!hresetn)
        (tick || reload) |=> (count_q == $past(divide_down));
    endproperty
    a_reload_at_zero: assert property (p_reload_at_zero) else $error("prescale not reloaded");

endmodule
`default_nettype wire

// ==== cpt_timer_ctrl.sv ====
// Control, prescale and main counter of a 32-bit down-counting timer with
// an AHB-Lite register slave and one level interrupt.
// Assumes a single AHB-Lite master, word transfers only, and a debug halt
// request synchronous to hclk.
`timescale 1ns/100ps
`default_nettype none
`include "cpt_consts.svh"

module cpt_timer_ctrl (
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Debugger breakpoint request.
    input  wire logic        debug_halt,
    // Interrupt and status.
    output logic             irq,
    output logic             timer_running
);

    cpt_pkg::cpt_bus_state_type bus_q;
    cpt_pkg::cpt_bus_state_type bus_d;
    logic [7:0]  addr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_mux;
    logic        take;
    logic        wr_en;
    logic        halt_q;
    logic        irq_en_q;
    logic        free_q;
    logic        soft_q;
    logic        flag_q;
    logic        emu_stop_q;
    logic [15:0] divide_q;
    logic [31:0] period_q;
    logic [31:0] main_q;
    logic [15:0] presc_count;
    logic        tick;
    logic        run;
    logic        reload;
    logic        hits_zero;
    logic        flag_clr;

    // An address phase is accepted only for a selected, active transfer.
    assign take  = hsel && htrans[1] && hready;
    assign wr_en = (bus_q == cpt_pkg::BUS_WRITE);

    // Reads take one wait state so that read data come from a register
    // sampled after any write of the previous transfer has landed.
    always_comb begin
        bus_d = cpt_pkg::BUS_IDLE;
        unique case (bus_q)
            cpt_pkg::BUS_RDWAIT: begin
                bus_d = cpt_pkg::BUS_RDOUT;
            end
            cpt_pkg::BUS_IDLE, cpt_pkg::BUS_WRITE, cpt_pkg::BUS_RDOUT: begin
                if (take) begin
                    bus_d = hwrite ? cpt_pkg::BUS_WRITE : cpt_pkg::BUS_RDWAIT;
                end
            end
        endcase
    end

    // Bus state and latched address.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_q  <= cpt_pkg::BUS_IDLE;
            addr_q <= 8'h00;
        end else begin
            bus_q <= bus_d;
            if (take) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    assign hreadyout = (bus_q != cpt_pkg::BUS_RDWAIT);
    assign hresp     = 1'b0;    // Always OKAY; unmapped reads give zero.
    assign hrdata    = hrdata_q;

    // Read view; the reload strobe and reserved bits read as zero.
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (addr_q)
            `CPT_OFS_CTRL: begin
                rd_mux[`CPT_BIT_FLAG]   = flag_q;
                rd_mux[`CPT_BIT_IRQ_EN] = irq_en_q;
                rd_mux[`CPT_BIT_FREE]   = free_q;
                rd_mux[`CPT_BIT_SOFT]   = soft_q;
                rd_mux[`CPT_BIT_HALT]   = halt_q;
            end
            `CPT_OFS_PRESC_LO: rd_mux[15:0] = {presc_count[7:0], divide_q[7:0]};
            `CPT_OFS_PRESC_HI: rd_mux[15:0] = {presc_count[15:8], divide_q[15:8]};
            `CPT_OFS_MAIN:     rd_mux = main_q;
            `CPT_OFS_PERIOD:   rd_mux = period_q;
            `CPT_OFS_IRQ_STAT: rd_mux[`CPT_BIT_EV_ZERO] = flag_q;
            `CPT_OFS_IRQ_EN:   rd_mux[`CPT_BIT_EV_ZERO] = irq_en_q;
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data register, loaded during the wait state.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (bus_q == cpt_pkg::BUS_RDWAIT) begin
            hrdata_q <= rd_mux;
        end
    end

    // Control word bits written by software.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            halt_q   <= 1'b0;
            irq_en_q <= 1'b0;
            free_q   <= 1'b0;
            soft_q   <= 1'b0;
        end else if (wr_en && addr_q == `CPT_OFS_CTRL) begin
            halt_q   <= hwdata[`CPT_BIT_HALT];
            irq_en_q <= hwdata[`CPT_BIT_IRQ_EN];
            free_q   <= hwdata[`CPT_BIT_FREE];
            soft_q   <= hwdata[`CPT_BIT_SOFT];
        end else if (wr_en && addr_q == `CPT_OFS_IRQ_EN) begin
            irq_en_q <= hwdata[`CPT_BIT_EV_ZERO];
        end
    end

    // Divide-down and period values; software sets the divide-down to the
    // wanted stretch factor minus one.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            divide_q <= `CPT_RST_DIVIDE;
            period_q <= `CPT_RST_PERIOD;
        end else if (wr_en) begin
            if (addr_q == `CPT_OFS_PRESC_LO) begin
                divide_q[7:0] <= hwdata[7:0];
            end
            if (addr_q == `CPT_OFS_PRESC_HI) begin
                divide_q[15:8] <= hwdata[7:0];
            end
            if (addr_q == `CPT_OFS_PERIOD) begin
                period_q <= hwdata;
            end
        end
    end

    // Only a written one fires the reload strobe; a zero does nothing.
    assign reload = wr_en && (addr_q == `CPT_OFS_CTRL) && hwdata[`CPT_BIT_RELOAD];
    // Free run masks a pending breakpoint stop at once, so setting it never
    // leaves the timer idle for the cycle that the stop flop takes to clear.
    assign run    = !halt_q && !(emu_stop_q && !free_q);
    assign timer_running = run;

    cpt_prescaler u_presc (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .run         (run),
        .reload      (reload),
        .divide_down (divide_q),
        .count_q     (presc_count),
        .tick        (tick)
    );

    // The main counter steps on a prescale tick; a 1 to 0 step is the event.
    // A strobe or a software write in the same cycle overrides the step, so
    // no zero is reached then and the flag must stay put.
    assign hits_zero = tick && (main_q == 32'h0000_0001) && !reload
                    && !(wr_en && addr_q == `CPT_OFS_MAIN);

    // Main counter: strobe beats a software write, which beats a tick.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_q <= `CPT_RST_MAIN;
        end else if (reload) begin
            main_q <= period_q;
        end else if (wr_en && addr_q == `CPT_OFS_MAIN) begin
            main_q <= hwdata;
        end else if (tick) begin
            if (main_q == 32'h0000_0000) begin
                main_q <= period_q;
            end else begin
                main_q <= main_q - 32'h0000_0001;
            end
        end
    end

    // Clearing comes from a one in the flag bit or in the clear register.
    assign flag_clr = wr_en && (((addr_q == `CPT_OFS_CTRL) && hwdata[`CPT_BIT_FLAG])
                    || ((addr_q == `CPT_OFS_IRQ_CLR) && hwdata[`CPT_BIT_EV_ZERO]));

    // Sticky zero flag; a new event in the clearing cycle is kept.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_q <= 1'b0;
        end else if (hits_zero) begin
            flag_q <= 1'b1;
        end else if (flag_clr) begin
            flag_q <= 1'b0;
        end
    end

    assign irq = flag_q && irq_en_q;

    // Breakpoint stop: free run ignores it, otherwise the stop lands on the
    // next step, or in soft mode on the step that reaches zero, so in soft
    // mode the flag is always set by then.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            emu_stop_q <= 1'b0;
        end else if (!debug_halt || free_q) begin
            emu_stop_q <= 1'b0;
        end else if (tick && (!soft_q || hits_zero)) begin
            emu_stop_q <= 1'b1;
        end
    end

    // Free run keeps the timer counting through a breakpoint.
    property p_free_runs;
        @(posedge hclk) disable iff (!hresetn)
        (free_q && !halt_q) |-> run;
    endproperty
    a_free_runs: assert property (p_free_runs) else $error("free run stopped by debug");

    // Hard stop halts right after the next step.
    property p_hard_stop;
        @(posedge hclk) disable iff (!hresetn)
        (debug_halt && !free_q && !soft_q && tick) ##1 (debug_halt && !free_q) |-> !run;
    endproperty
    a_hard_stop: assert property (p_hard_stop) else $error("hard stop missed");

    // Soft stop only ever follows a flag-setting step.
    property p_soft_flag;
        @(posedge hclk) disable iff (!hresetn)
        ($rose(emu_stop_q) && $past(soft_q)) |-> flag_q;
    endproperty
    a_soft_flag: assert property (p_soft_flag) else $error("soft stop before flag");

    // A step to zero sets the flag on the next edge.
    property p_flag_set;
        @(posedge hclk) disable iff (!hresetn)
        hits_zero |=> flag_q;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("zero flag not set");

    // Interrupt follows the flag only under the enable.
    property p_irq_gate;
        @(posedge hclk) disable iff (!hresetn)
        irq |-> (irq_en_q && flag_q);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

    // The strobe loads the period into the main counter.
    property p_reload;
        @(posedge hclk) disable iff (!hresetn)
        reload |=> (main_q == $past(period_q) && presc_count == $past(divide_q));
    endproperty
    a_reload: assert property (p_reload) else $error("reload strobe lost");

    // While halted by software the counters hold still.
    property p_halt_holds;
        @(posedge hclk) disable iff (!hresetn)
        (halt_q && !reload && !wr_en) |=> $stable(main_q) && $stable(presc_count);
    endproperty
    a_halt_holds: assert property (p_halt_holds) else $error("counting while halted");

    // A step below zero wraps to the period value.
    property p_wrap;
        @(posedge hclk) disable iff (!hresetn)
        (tick && main_q == 32'h0000_0000 && !reload && !wr_en) |=> (main_q == $past(period_q));
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap to period");

endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the timer control slice, driven over its AHB-Lite port.
// Assumes the constants header is on the include path and a single hclk domain.
`timescale 1ns/100ps
`default_nettype none
`include "cpt_consts.svh"

module tb;
    // Control word bit masks.
    localparam logic [31:0] c_halt = 32'h0000_0001 << `CPT_BIT_HALT;
    localparam logic [31:0] c_rld  = 32'h0000_0001 << `CPT_BIT_RELOAD;
    localparam logic [31:0] c_free = 32'h0000_0001 << `CPT_BIT_FREE;
    localparam logic [31:0] c_soft = 32'h0000_0001 << `CPT_BIT_SOFT;
    localparam logic [31:0] c_en   = 32'h0000_0001 << `CPT_BIT_IRQ_EN;
    localparam logic [31:0] c_flag = 32'h0000_0001 << `CPT_BIT_FLAG;

    // Design connections and bench state.
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        debug_halt;
    wire logic   hreadyout;
    wire logic   hresp;
    wire logic [31:0] hrdata;
    wire logic   irq;
    wire logic   timer_running;
    int          err_count;
    int          tests_run;
    int          seed;
    int          cyc;
    int          c1;
    int          k;
    int          n;
    logic [31:0] rd;
    logic [31:0] m1;
    logic [15:0] m_div;
    logic [31:0] m_period;

    // The single slave's ready is the bus ready.
    cpt_timer_ctrl u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .debug_halt(debug_halt),
        .irq(irq), .timer_running(timer_running));

    // Free-running clock and a cycle count used to time the main counter.
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
    end

    task automatic stop_test;
        $display("Summary: %0d comparisons, %0d mismatches", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        $display("[ERR] %0t %s", $time, msg);
        err_count++;
    endtask

    task automatic chk_word(input logic [31:0] exp, input logic [31:0] got, input string w);
        tests_run++;
        if (got !== exp) fail($sformatf("%s expected %h got %h", w, exp, got));
    endtask

    task automatic chk_bit(input logic exp, input logic got, input string w);
        tests_run++;
        if (got !== exp) fail($sformatf("%s expected %b got %b", w, exp, got));
    endtask

    // Ready is looked at on the falling edge, half a cycle before the rising edge, where it has settled.
    task automatic wait_ready;
        int t;
        t = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1 && t < 100) begin
            @(negedge hclk);
            t++;
        end
        if (t >= 100) begin
            fail("bus wait timed out");
            stop_test();
        end
        if (hresp !== 1'b0) fail("error response on bus");
        rd = hrdata;
        @(posedge hclk);
    endtask

    // One single word transfer; read data lands in rd.
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        hsize  <= 3'b010;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk_word(exp, rd, $sformatf("read %h", a));
    endtask

    // Main counter steps against elapsed cycles; one step of slack for the read phase.
    task automatic rate(input int d);
        int span;
        int dm;
        bus(1'b0, `CPT_OFS_MAIN, 32'h0000_0000);
        m1 = rd;
        c1 = cyc;
        repeat (40) @(posedge hclk);
        bus(1'b0, `CPT_OFS_MAIN, 32'h0000_0000);
        span = cyc - c1;
        dm = int'(m1 - rd);
        tests_run++;
        if (dm < span / (d + 1) - 1 || dm > span / (d + 1) + 1) begin
            fail($sformatf("main stepped %0d in %0d cycles", dm, span));
        end
    endtask

    // Main sequence.
    initial begin
        seed = 32'hbfa1_9566;
        cyc = 0;
        err_count = 0;
        tests_run = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        debug_halt = 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk_bit(1'b1, timer_running, "running after reset");
        rdchk(`CPT_OFS_CTRL, 32'h0000_0000);
        rdchk(`CPT_OFS_PRESC_LO, 32'h0000_0000);
        rdchk(`CPT_OFS_PRESC_HI, 32'h0000_0000);
        rdchk(`CPT_OFS_PERIOD, `CPT_RST_PERIOD);
        rdchk(`CPT_OFS_IRQ_STAT, 32'h0000_0000);
        wr(32'h0000_0040, $random(seed));
        rdchk(32'h0000_0040, 32'h0000_0000);
        rate(0);
        $display("test reset done");

        // Stop, load period and divide-down, then reload while stopped.
        wr(`CPT_OFS_CTRL, c_halt);
        @(negedge hclk);
        chk_bit(1'b0, timer_running, "stopped");
        rdchk(`CPT_OFS_CTRL, c_halt);
        m_period = $random(seed);
        m_div = 16'($random(seed));
        wr(`CPT_OFS_PERIOD, m_period);
        wr(`CPT_OFS_PRESC_LO, {24'h00_0000, m_div[7:0]});
        wr(`CPT_OFS_PRESC_HI, {24'h00_0000, m_div[15:8]});
        wr(`CPT_OFS_CTRL, c_halt | c_rld);
        rdchk(`CPT_OFS_MAIN, m_period);
        rdchk(`CPT_OFS_PRESC_LO, {16'h0000, m_div[7:0], m_div[7:0]});
        rdchk(`CPT_OFS_PRESC_HI, {16'h0000, m_div[15:8], m_div[15:8]});
        rdchk(`CPT_OFS_CTRL, c_halt);
        wr(`CPT_OFS_PRESC_LO, {24'h00_00FF, m_div[7:0]});
        rdchk(`CPT_OFS_PRESC_LO, {16'h0000, m_div[7:0], m_div[7:0]});
        wr(`CPT_OFS_MAIN, 32'h1234_5678);
        wr(`CPT_OFS_CTRL, c_halt);
        rdchk(`CPT_OFS_MAIN, 32'h1234_5678);
        // Small divide-down and restart, then check the step rate.
        m_div = 16'(($random(seed) & 6) + 1);
        wr(`CPT_OFS_PRESC_LO, {16'h0000, m_div});
        wr(`CPT_OFS_PRESC_HI, 32'h0000_0000);
        wr(`CPT_OFS_PERIOD, 32'hFFFF_FFF0);
        wr(`CPT_OFS_CTRL, c_halt | c_rld);
        wr(`CPT_OFS_CTRL, 32'h0000_0000);
        @(negedge hclk);
        chk_bit(1'b1, timer_running, "restarted");
        rate(int'(m_div));
        bus(1'b0, `CPT_OFS_PRESC_LO, 32'h0000_0000);
        chk_bit(1'b1, rd[15:8] <= m_div[7:0], "prescale within range");
        $display("test reload and prescale done");

        // Zero flag, interrupt and wrap; clear through control word, then clear register.
        for (k = 0; k < 2; k++) begin
            wr(`CPT_OFS_CTRL, c_halt);
            wr(`CPT_OFS_PRESC_LO, 32'h0000_0000);
            wr(`CPT_OFS_PERIOD, 32'h0000_0014);
            wr(`CPT_OFS_MAIN, 32'h0000_0006);
            wr(`CPT_OFS_CTRL, 32'h0000_0000);
            n = 0;
            rd = 32'h0000_0000;
            while (rd[0] !== 1'b1 && n < 20) begin
                bus(1'b0, `CPT_OFS_IRQ_STAT, 32'h0000_0000);
                chk_bit(1'b0, irq, "irq while disabled");
                n++;
            end
            chk_word(32'h0000_0001, rd, "flag set");
            wr(`CPT_OFS_CTRL, c_halt);
            if (k == 0) wr(`CPT_OFS_CTRL, c_halt | c_en);
            else wr(`CPT_OFS_IRQ_EN, 32'h0000_0001);
            @(negedge hclk);
            chk_bit(1'b1, irq, "irq enabled");
            rdchk(`CPT_OFS_CTRL, c_halt | c_en | c_flag);
            bus(1'b0, `CPT_OFS_MAIN, 32'h0000_0000);
            chk_bit(1'b1, rd <= 32'h0000_0014, "main wrapped to period");
            wr(`CPT_OFS_CTRL, c_halt | c_en);
            rdchk(`CPT_OFS_IRQ_STAT, 32'h0000_0001);
            if (k == 0) wr(`CPT_OFS_CTRL, c_halt | c_en | c_flag);
            else wr(`CPT_OFS_IRQ_CLR, 32'h0000_0001);
            @(negedge hclk);
            chk_bit(1'b0, irq, "irq after clear");
            rdchk(`CPT_OFS_IRQ_STAT, 32'h0000_0000);
            wr(`CPT_OFS_IRQ_EN, 32'h0000_0000);
        end
        $display("test flag and interrupt done");

        // Breakpoint behaviour: free run, soft stop, hard stop.
        wr(`CPT_OFS_MAIN, 32'h0000_0008);
        wr(`CPT_OFS_CTRL, c_free | c_soft);
        debug_halt <= 1'b1;
        repeat (12) begin
            @(negedge hclk);
            chk_bit(1'b1, timer_running, "free run");
        end
        @(posedge hclk);
        debug_halt <= 1'b0;
        wr(`CPT_OFS_CTRL, c_halt | c_flag);
        wr(`CPT_OFS_MAIN, 32'h0000_0008);
        wr(`CPT_OFS_CTRL, c_soft);
        debug_halt <= 1'b1;
        n = 0;
        @(negedge hclk);
        while (timer_running !== 1'b0 && n < 40) begin
            @(negedge hclk);
            n++;
        end
        chk_bit(1'b0, timer_running, "soft stop");
        rdchk(`CPT_OFS_IRQ_STAT, 32'h0000_0001);
        rdchk(`CPT_OFS_MAIN, 32'h0000_0000);
        debug_halt <= 1'b0;
        wr(`CPT_OFS_CTRL, 32'h0000_0000);
        debug_halt <= 1'b1;
        repeat (3) @(negedge hclk);
        chk_bit(1'b0, timer_running, "hard stop");
        bus(1'b0, `CPT_OFS_MAIN, 32'h0000_0000);
        m1 = rd;
        rdchk(`CPT_OFS_MAIN, m1);
        debug_halt <= 1'b0;
        repeat (2) @(negedge hclk);
        chk_bit(1'b1, timer_running, "resumed");
        $display("test breakpoint done");
        stop_test();
    end
endmodule
`default_nettype wire
